/* idw_pkg.sv */
package idw_pkg;

   // ---------------------------------------------------------------
   // Word indices served by the block.
   // ---------------------------------------------------------------
   localparam logic [7:0] W_CAPS = 8'h31;       // Word 49.
   localparam logic [7:0] W_PIO_LEGACY = 8'h33; // Word 51.
   localparam logic [7:0] W_VALID = 8'h35;      // Word 53.
   localparam logic [7:0] W_CUR_CYL = 8'h36;    // Word 54.
   localparam logic [7:0] W_CUR_HEADS = 8'h37;  // Word 55.
   localparam logic [7:0] W_CUR_SPT = 8'h38;    // Word 56.
   localparam logic [7:0] W_CAP_LO = 8'h39;     // Word 57.
   localparam logic [7:0] W_CAP_HI = 8'h3A;     // Word 58.
   localparam logic [7:0] W_MULT = 8'h3B;       // Word 59.
   localparam logic [7:0] W_LBA_LO = 8'h3C;     // Word 60.
   localparam logic [7:0] W_LBA_HI = 8'h3D;     // Word 61.
   localparam logic [7:0] W_MDMA = 8'h3F;       // Word 63.
   localparam logic [7:0] W_PIO_ADV = 8'h40;    // Word 64.
   localparam logic [7:0] W_DMA_MIN = 8'h41;    // Word 65.
   localparam logic [7:0] W_DMA_REC = 8'h42;    // Word 66.
   localparam logic [7:0] W_PIO_MIN = 8'h43;    // Word 67.
   localparam logic [7:0] W_PIO_IORDY = 8'h44;  // Word 68.

   // ---------------------------------------------------------------
   // Field positions.
   // ---------------------------------------------------------------
   localparam int B_STBY = 13;
   localparam int B_IORDY_SUP = 11;
   localparam int B_IORDY_DIS = 10;
   localparam int B_LBA = 9;
   localparam int B_DMA = 8;
   localparam int B_VAL_GEOM = 0;
   localparam int B_VAL_ADV = 1;
   localparam int B_VAL_UDMA = 2;
   localparam int B_MULT_VALID = 8;

   // ---------------------------------------------------------------
   // Fixed values, mode limits and reset values.
   // ---------------------------------------------------------------
   localparam logic [7:0] LEGACY_PIO_BYTE = 8'h02;
   localparam logic [15:0] CYCLE_NS = 16'h0078;
   localparam logic [2:0] MDMA_WORD_MAX = 3'h2;
   localparam logic [2:0] PIO_MODE3 = 3'h3;
   localparam logic [2:0] PIO_MODE4 = 3'h4;
   localparam logic [15:0] RD_DATA_RST = 16'h0000;
   localparam logic [31:0] CAP_RST = 32'h0000_0000;
   localparam int CAP_LATENCY = 2;

endpackage

/* idw_capmul.sv */
`timescale 1ns/1ns

module idw_capmul
   import idw_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] cyl,
   input wire logic [15:0] heads,
   input wire logic [15:0] spt,
   output logic [31:0] cap
);

   // ---------------------------------------------------------------
   // Two-stage capacity product.
   // ---------------------------------------------------------------

   logic [31:0] part_ff;
   logic [31:0] cap_ff;
   logic [47:0] nxt_full;

   // Splitting the triple product keeps each multiplier 32 or 48 wide,
   // at the cost of two cycles of lag after a geometry change.
   assign nxt_full = 48'(part_ff) * 48'(spt);

   // First stage multiplies cylinders by heads.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         part_ff <= CAP_RST;
      else
         part_ff <= 32'(cyl) * 32'(heads);
   end

   // Second stage keeps the low double word only.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cap_ff <= CAP_RST;
      else
         cap_ff <= nxt_full[31:0];
   end

   assign cap = cap_ff;

endmodule

/* idw_capwords.sv */
//
// Behaviour
// RQ1: Capabilities bit 13 reads zero; standby timer is maker defined.
// RQ2: Capabilities bit 11 at one reports IORDY supported.
// RQ3: Capabilities bit 10 reads zero; IORDY cannot be disabled.
// RQ4: Capabilities bit 9 reports LBA, bit 8 reports DMA commands.
// RQ5: Word 51 upper byte is 02 hex, the legacy PIO mode.
// RQ6: Word 53 bits 0,1,2 flag words 54-58, 64-70, 88 valid.
// RQ7: Words 54 to 56 give current cylinders, heads, sectors per track.
// RQ8: Words 57 and 58 give the product of current geometry.
// RQ9: Word 59 has bit 8 set and a count of zero or one.
// RQ10: Words 60 and 61 give total LBA addressable sectors.
// RQ11: Word 63 upper byte has at most one bit set.
// RQ12: Bits 8, 9, 10 select DMA modes 0, 1, 2; 15-11 zero.
// RQ13: Word 63 lower byte flags supported modes cumulatively; 7-3 zero.
// RQ14: DMA modes three and above never show in word 63.
// RQ15: Word 64 bit 0 for PIO mode 3, bit 1 for mode 4.
// RQ16: Word 65 gives minimum DMA cycle, not below fastest mode.
// RQ17: Word 66 recommended DMA cycle is never below word 65.
// RQ18: Unsupported words 65 or 66 read zero.
// RQ19: Word 67 filled for PIO mode 3 and up, not below 68.
// RQ20: Word 68 gives fastest PIO cycle with IORDY flow control.
// RQ21: Unsupported words 67 or 68 read zero.
// RQ22: Host keeps its PIO cycle at or above the word 67 value.
// RQ23: Words 65-68 read 120 ns; 65 and 66 zero in removable mode.
// RQ24: One word answered per request from constants and live inputs.
//
`timescale 1ns/1ns

module idw_capwords
   import idw_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic rd_req,
   input wire logic [7:0] rd_index,
   input wire logic iordy_sup,
   input wire logic udma_word_valid,
   input wire logic removable_mode,
   input wire logic [15:0] cur_cyl,
   input wire logic [15:0] cur_heads,
   input wire logic [15:0] cur_spt,
   input wire logic [31:0] lba_total,
   input wire logic mult_one,
   input wire logic mdma_sel_en,
   input wire logic [2:0] mdma_sel_mode,
   input wire logic mdma_sup_en,
   input wire logic [2:0] mdma_sup_mode,
   input wire logic [2:0] pio_max_mode,
   output logic rd_valid,
   output logic [15:0] rd_data,
   output logic rd_hit
);

   // ---------------------------------------------------------------
   // Declarations.
   // ---------------------------------------------------------------

   logic rd_valid_ff;
   logic [15:0] rd_data_ff;
   logic rd_hit_ff;
   logic [15:0] nxt_data;
   logic nxt_hit;
   logic [31:0] cap;
   logic [15:0] w_caps;
   logic [15:0] w_valid;
   logic [15:0] w_mult;
   logic [7:0] mdma_sel_byte;
   logic [7:0] mdma_sup_byte;
   logic [15:0] w_pio_adv;
   logic dma_fields_on;
   logic pio_fields_on;

   // ---------------------------------------------------------------
   // Capacity product.
   // ---------------------------------------------------------------

   // The product is pipelined; geometry is expected to sit still for
   // a few cycles after a translation change before words 57-58 are read.
   idw_capmul u_capmul
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .cyl(cur_cyl),
      .heads(cur_heads),
      .spt(cur_spt),
      .cap(cap) // RQ8
   );

   // ---------------------------------------------------------------
   // Word assembly.
   // ---------------------------------------------------------------

   // Capabilities: standby and IORDY-disable bits stay clear, LBA and
   // DMA are always offered, IORDY support follows the strap input.
   always_comb
   begin
      w_caps = 16'h0000;
      w_caps[B_STBY] = 1'b0; // RQ1
      w_caps[B_IORDY_SUP] = iordy_sup; // RQ2
      w_caps[B_IORDY_DIS] = 1'b0; // RQ3
      w_caps[B_LBA] = 1'b1; // RQ4
      w_caps[B_DMA] = 1'b1; // RQ4
   end

   // Validity flags; the advanced words are always served here.
   always_comb
   begin
      w_valid = 16'h0000;
      w_valid[B_VAL_GEOM] = 1'b1; // RQ6
      w_valid[B_VAL_ADV] = 1'b1; // RQ6
      w_valid[B_VAL_UDMA] = udma_word_valid; // RQ6
   end

   // Multiple setting: the count is clamped to the two legal values.
   always_comb
   begin
      w_mult = 16'h0000;
      w_mult[B_MULT_VALID] = 1'b1; // RQ9
      w_mult[0] = mult_one; // RQ9
   end

   // Selected DMA mode as a one-hot byte; modes past two are reported
   // elsewhere, so they leave the byte empty rather than wrap.
   always_comb
   begin
      mdma_sel_byte = 8'h00;
      if (mdma_sel_en && (mdma_sel_mode <= MDMA_WORD_MAX)) // RQ14
         mdma_sel_byte[mdma_sel_mode] = 1'b1; // RQ11 RQ12
   end

   // Supported DMA modes as a thermometer code, capped at mode two.
   generate
      for (genvar m = 0; m < 8; m++)
      begin : g_sup
         if (m <= 2)
         begin : g_live
            assign mdma_sup_byte[m] = mdma_sup_en &&
               (mdma_sup_mode >= 3'(m)); // RQ13 RQ14
         end
         else
         begin : g_rsvd
            assign mdma_sup_byte[m] = 1'b0; // RQ13
         end
      end
   endgenerate

   // Advanced PIO support bits from the fastest mode offered.
   always_comb
   begin
      w_pio_adv = 16'h0000;
      w_pio_adv[0] = (pio_max_mode >= PIO_MODE3); // RQ15
      w_pio_adv[1] = (pio_max_mode >= PIO_MODE4); // RQ15
   end

   // The DMA timing words exist only with DMA support and never in the
   // removable-card interface; the PIO timing words need mode 3 or up.
   assign dma_fields_on = mdma_sup_en && !removable_mode; // RQ18 RQ23
   assign pio_fields_on = (pio_max_mode >= PIO_MODE3); // RQ19 RQ21

   // ---------------------------------------------------------------
   // Word select.
   // ---------------------------------------------------------------

   // Every word except 57-58, which come from the capacity pipeline, is built
   // from its live inputs at the moment of the request, so a mode change is visible on the next read.
   always_comb
   begin
      nxt_data = 16'h0000;
      nxt_hit = 1'b1;
      case (rd_index)
         W_CAPS: nxt_data = w_caps;
         W_PIO_LEGACY: nxt_data = {LEGACY_PIO_BYTE, 8'h00}; // RQ5
         W_VALID: nxt_data = w_valid;
         W_CUR_CYL: nxt_data = cur_cyl; // RQ7
         W_CUR_HEADS: nxt_data = cur_heads; // RQ7
         W_CUR_SPT: nxt_data = cur_spt; // RQ7
         W_CAP_LO: nxt_data = cap[15:0]; // RQ8
         W_CAP_HI: nxt_data = cap[31:16]; // RQ8
         W_MULT: nxt_data = w_mult;
         W_LBA_LO: nxt_data = lba_total[15:0]; // RQ10
         W_LBA_HI: nxt_data = lba_total[31:16]; // RQ10
         W_MDMA: nxt_data = {mdma_sel_byte, mdma_sup_byte};
         W_PIO_ADV: nxt_data = w_pio_adv;
         W_DMA_MIN: nxt_data = dma_fields_on ? CYCLE_NS : 16'h0000; // RQ16
         W_DMA_REC: nxt_data = dma_fields_on ? CYCLE_NS : 16'h0000; // RQ17
         W_PIO_MIN: nxt_data = pio_fields_on ? CYCLE_NS : 16'h0000; // RQ19
         W_PIO_IORDY: nxt_data = pio_fields_on ? CYCLE_NS : 16'h0000; // RQ20
         default: nxt_hit = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // Answer registers.
   // ---------------------------------------------------------------

   // One answer strobe per request, one cycle after it.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rd_valid_ff <= 1'b0;
      else
         rd_valid_ff <= rd_req; // RQ24
   end

   // Data and hit hold their last answer between requests, so a slow
   // reader may sample them after the strobe has gone.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rd_data_ff <= RD_DATA_RST;
         rd_hit_ff <= 1'b0;
      end
      else if (rd_req)
      begin
         rd_data_ff <= nxt_data; // RQ24
         rd_hit_ff <= nxt_hit;
      end
   end

   assign rd_valid = rd_valid_ff;
   assign rd_data = rd_data_ff;
   assign rd_hit = rd_hit_ff;

   // ---------------------------------------------------------------
   // Assertions.
   // ---------------------------------------------------------------

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   logic [47:0] chk_full;
   assign chk_full = 48'(cur_cyl) * 48'(cur_heads) * 48'(cur_spt);

   sequence s_req(logic [7:0] w);
      rd_req && (rd_index == w);
   endsequence

   sequence s_geom_still;
      $stable(cur_cyl) && $stable(cur_heads) && $stable(cur_spt);
   endsequence

   property p_caps;
      s_req(W_CAPS) |=> rd_valid && !rd_data[B_STBY] &&
         !rd_data[B_IORDY_DIS] && rd_data[B_LBA] && rd_data[B_DMA] &&
         (rd_data[B_IORDY_SUP] == $past(iordy_sup));
   endproperty
   a_caps: assert property (p_caps) // RQ1 RQ2 RQ3 RQ4
      else $error("Capabilities word is wrong.");

   property p_legacy;
      s_req(W_PIO_LEGACY) |=> rd_data[15:8] == LEGACY_PIO_BYTE;
   endproperty
   a_legacy: assert property (p_legacy) // RQ5
      else $error("Legacy PIO byte is wrong.");

   property p_valid;
      s_req(W_VALID) |=> rd_data[1:0] == 2'h3 &&
         rd_data[B_VAL_UDMA] == $past(udma_word_valid);
   endproperty
   a_valid: assert property (p_valid) // RQ6
      else $error("Validity word is wrong.");

   property p_cyl;
      s_req(W_CUR_CYL) |=> rd_data == $past(cur_cyl);
   endproperty
   a_cyl: assert property (p_cyl) // RQ7
      else $error("Cylinder word does not follow input.");

   property p_cap;
      s_geom_still [*3] ##0 s_req(W_CAP_LO)
         |=> rd_data == $past(chk_full[15:0]);
   endproperty
   a_cap: assert property (p_cap) // RQ8
      else $error("Capacity low word is not the geometry product.");

   property p_mult;
      s_req(W_MULT) |=> rd_data[15:9] == 7'h00 && rd_data[8] &&
         rd_data[7:0] == {7'h00, $past(mult_one)};
   endproperty
   a_mult: assert property (p_mult) // RQ9
      else $error("Multiple setting word is wrong.");

   property p_lba;
      s_req(W_LBA_HI) |=> rd_data == $past(lba_total[31:16]);
   endproperty
   a_lba: assert property (p_lba) // RQ10
      else $error("LBA high word does not follow input.");

   property p_sel;
      s_req(W_MDMA) |=> $onehot0(rd_data[15:8]) &&
         rd_data[15:11] == 5'h00;
   endproperty
   a_sel: assert property (p_sel) // RQ11 RQ12 RQ14
      else $error("Selected DMA byte is illegal.");

   property p_sel_map;
      s_req(W_MDMA) ##0 (mdma_sel_en && mdma_sel_mode == 3'h1)
         |=> rd_data[15:8] == 8'h02;
   endproperty
   a_sel_map: assert property (p_sel_map) // RQ12
      else $error("Selected DMA mode one is not on bit 9.");

   property p_sup;
      s_req(W_MDMA) |=> rd_data[7:3] == 5'h00 &&
         (!rd_data[2] || rd_data[1]) && (!rd_data[1] || rd_data[0]);
   endproperty
   a_sup: assert property (p_sup) // RQ13
      else $error("Supported DMA byte is not cumulative.");

   property p_pio_adv;
      s_req(W_PIO_ADV) |=> rd_data[15:2] == 14'h0000 &&
         rd_data[0] == ($past(pio_max_mode) >= PIO_MODE3) &&
         rd_data[1] == ($past(pio_max_mode) >= PIO_MODE4);
   endproperty
   a_pio_adv: assert property (p_pio_adv) // RQ15
      else $error("Advanced PIO word is wrong.");

   property p_dma_min;
      s_req(W_DMA_MIN) |=> rd_data ==
         (($past(mdma_sup_en) && !$past(removable_mode)) ?
         CYCLE_NS : 16'h0000);
   endproperty
   a_dma_min: assert property (p_dma_min) // RQ16 RQ18 RQ23
      else $error("Minimum DMA cycle word is wrong.");

   property p_dma_rec;
      s_req(W_DMA_REC) ##0 removable_mode |=> rd_data == 16'h0000;
   endproperty
   a_dma_rec: assert property (p_dma_rec) // RQ17 RQ23
      else $error("Recommended DMA word not zero in removable mode.");

   property p_pio_min;
      s_req(W_PIO_MIN) |=> rd_data ==
         (($past(pio_max_mode) >= PIO_MODE3) ? CYCLE_NS : 16'h0000);
   endproperty
   a_pio_min: assert property (p_pio_min) // RQ19 RQ21
      else $error("Minimum PIO cycle word is wrong.");

   property p_pio_iordy;
      s_req(W_PIO_IORDY) ##0 (pio_max_mode < PIO_MODE3)
         |=> rd_data == 16'h0000;
   endproperty
   a_pio_iordy: assert property (p_pio_iordy) // RQ20 RQ21
      else $error("IORDY PIO word not zero without mode 3.");

   property p_answer;
      rd_req |=> rd_valid ##1 (rd_valid == $past(rd_req));
   endproperty
   a_answer: assert property (p_answer) // RQ24
      else $error("Answer strobe does not track requests.");

   property p_hold;
      !rd_req |=> $stable(rd_data) && $stable(rd_hit);
   endproperty
   a_hold: assert property (p_hold) // RQ24
      else $error("Answer data moved without a request.");

endmodule

/* idw_host.sv */
`timescale 1ns/1ns

// ---------------------------------------------------------------
// Host-side reader of the identify parameter words.
// ---------------------------------------------------------------
module idw_host
   import idw_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic [7:0] index,
   output logic req_ff,
   output logic [7:0] idx_ff,
   input wire logic rd_valid,
   input wire logic [15:0] rd_data,
   input wire logic rd_hit,
   output logic done_ff,
   output logic [15:0] got_data_ff,
   output logic got_hit_ff,
   output logic [15:0] pio_cycle_ff
);
   logic [7:0] taken_ff;

   // Request side: the index is scrambled when idle, so a design that
   // samples it outside a request cannot pass by luck.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         req_ff <= 1'b0;
         idx_ff <= 8'h00;
         taken_ff <= 8'h00;
      end
      else
      begin
         req_ff <= start;
         idx_ff <= start ? index : ~idx_ff;
         if (req_ff)
         begin
            taken_ff <= idx_ff;
         end
      end
   end

   // Answer side: capture each answer and adopt the reported PIO minimum.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         done_ff <= 1'b0;
         got_data_ff <= 16'h0000;
         got_hit_ff <= 1'b0;
         pio_cycle_ff <= 16'h0258; // Slow safe default before identify.
      end
      else
      begin
         done_ff <= rd_valid;
         if (rd_valid)
         begin
            got_data_ff <= rd_data;
            got_hit_ff <= rd_hit;
         end
         if (rd_valid && taken_ff == W_PIO_MIN && rd_data != 16'h0000)
         begin
            pio_cycle_ff <= rd_data;
         end
      end
   end
endmodule

/* tb_top.sv */
`timescale 1ns/1ns

module tb_top;
   import idw_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic start = 1'b0;
   logic [7:0] index = 8'h00;
   logic iordy_sup = 1'b0;
   logic udma_word_valid = 1'b0;
   logic removable_mode = 1'b0;
   logic [15:0] cur_cyl = 16'h0000;
   logic [15:0] cur_heads = 16'h0000;
   logic [15:0] cur_spt = 16'h0000;
   logic [31:0] lba_total = 32'h0000_0000;
   logic mult_one = 1'b0;
   logic mdma_sel_en = 1'b0;
   logic [2:0] mdma_sel_mode = 3'h0;
   logic mdma_sup_en = 1'b0;
   logic [2:0] mdma_sup_mode = 3'h0;
   logic [2:0] pio_max_mode = 3'h0;
   logic rd_req, rd_valid, rd_hit, done, got_hit;
   logic [7:0] rd_index;
   logic [15:0] rd_data, got_data, pio_cycle;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;

   // ---------------------------------------------------------------
   // Clock, block under test and host model.
   // ---------------------------------------------------------------
   always #25 clk = ~clk;

   idw_capwords DUT (.clk(clk), .sys_rst(sys_rst), .rd_req(rd_req),
      .rd_index(rd_index), .iordy_sup(iordy_sup),
      .udma_word_valid(udma_word_valid), .removable_mode(removable_mode),
      .cur_cyl(cur_cyl), .cur_heads(cur_heads), .cur_spt(cur_spt),
      .lba_total(lba_total), .mult_one(mult_one),
      .mdma_sel_en(mdma_sel_en), .mdma_sel_mode(mdma_sel_mode),
      .mdma_sup_en(mdma_sup_en), .mdma_sup_mode(mdma_sup_mode),
      .pio_max_mode(pio_max_mode), .rd_valid(rd_valid),
      .rd_data(rd_data), .rd_hit(rd_hit));

   idw_host host (.clk(clk), .sys_rst(sys_rst), .start(start),
      .index(index), .req_ff(rd_req), .idx_ff(rd_index),
      .rd_valid(rd_valid), .rd_data(rd_data), .rd_hit(rd_hit),
      .done_ff(done), .got_data_ff(got_data), .got_hit_ff(got_hit),
      .pio_cycle_ff(pio_cycle));

   // ---------------------------------------------------------------
   // Shared checking and reading tasks.
   // ---------------------------------------------------------------
   task automatic test_done();
      $display("Checks made %0d, mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] e,
                      input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask

   // Waits a bounded time for the host to report an answer.
   task automatic wait_answer(input logic [7:0] i, input logic [15:0] e,
                              input logic eh);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (done !== 1'b1 && n < 8);
      chk($sformatf("word %0d valid", i), 16'h0001, {15'h0000, done});
      chk($sformatf("word %0d data", i), e, got_data);
      chk($sformatf("word %0d hit", i), {15'h0000, eh}, {15'h0000, got_hit});
   endtask

   task automatic rd(input logic [7:0] i, input logic [15:0] e,
                     input logic eh);
      @(posedge clk);
      start <= 1'b1;
      index <= i;
      @(posedge clk);
      start <= 1'b0;
      wait_answer(i, e, eh);
   endtask

   // Two words requested back to back, low word first.
   task automatic rd2(input logic [7:0] i, input logic [15:0] e0,
                      input logic [15:0] e1);
      @(posedge clk);
      start <= 1'b1;
      index <= i;
      @(posedge clk);
      index <= i + 8'h01;
      @(posedge clk);
      start <= 1'b0;
      wait_answer(i, e0, 1'b1);
      @(posedge clk);
      #1;
      chk("second word valid", 16'h0001, {15'h0000, done});
      chk("second word data", e1, got_data);
      chk("second word hit", 16'h0001, {15'h0000, got_hit});
   endtask

   // ---------------------------------------------------------------
   // Scenarios.
   // ---------------------------------------------------------------
   task automatic t_flags();
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk);
         iordy_sup <= k[0];
         udma_word_valid <= k[0];
         mult_one <= k[0];
         rd(W_CAPS, 16'h0300 | (16'(k) << 11), 1'b1);
         rd(W_VALID, 16'h0003 | (16'(k) << 2), 1'b1);
         rd(W_MULT, 16'h0100 | 16'(k), 1'b1);
      end
      rd(W_PIO_LEGACY, 16'h0200, 1'b1);
      $display("t_flags finished");
   endtask

   task automatic t_geom(input logic [15:0] c, input logic [15:0] h,
                         input logic [15:0] s, input logic [31:0] l);
      logic [31:0] p;
      p = {16'h0000, c} * {16'h0000, h} * {16'h0000, s};
      @(posedge clk);
      cur_cyl <= c;
      cur_heads <= h;
      cur_spt <= s;
      lba_total <= l;
      rd(W_CUR_CYL, c, 1'b1);
      rd(W_CUR_HEADS, h, 1'b1);
      rd(W_CUR_SPT, s, 1'b1);
      rd2(W_CAP_LO, p[15:0], p[31:16]);
      rd2(W_LBA_LO, l[15:0], l[31:16]);
      $display("t_geom finished");
   endtask

   task automatic t_mdma();
      logic [7:0] hi, lo;
      int sm;
      for (int m = 0; m < 8; m++)
         for (int en = 0; en < 2; en++)
         begin
            sm = 7 - m;
            hi = (en == 1 && m <= 2) ? (8'h01 << m) : 8'h00;
            lo = (en == 0) ? 8'h00 : (sm >= 2) ? 8'h07 :
                 (sm == 1) ? 8'h03 : 8'h01;
            @(posedge clk);
            mdma_sel_en <= en[0];
            mdma_sel_mode <= m[2:0];
            mdma_sup_en <= en[0];
            mdma_sup_mode <= sm[2:0];
            rd(W_MDMA, {hi, lo}, 1'b1);
         end
      $display("t_mdma finished");
   endtask

   task automatic t_dma_time();
      logic [15:0] t;
      for (int k = 0; k < 4; k++)
      begin
         t = (k == 1) ? CYCLE_NS : 16'h0000;
         @(posedge clk);
         mdma_sup_en <= k[0];
         removable_mode <= k[1];
         rd(W_DMA_MIN, t, 1'b1);
         rd(W_DMA_REC, t, 1'b1);
      end
      $display("t_dma_time finished");
   endtask

   task automatic t_pio();
      logic [15:0] t;
      chk("host pio default", 16'h0258, pio_cycle);
      for (int m = 0; m < 8; m++)
      begin
         t = (m >= 3) ? CYCLE_NS : 16'h0000;
         @(posedge clk);
         pio_max_mode <= m[2:0];
         rd(W_PIO_ADV, {14'h0000, m >= 4, m >= 3}, 1'b1);
         rd(W_PIO_MIN, t, 1'b1);
         rd(W_PIO_IORDY, t, 1'b1);
      end
      chk("host pio adopted", CYCLE_NS, pio_cycle);
      $display("t_pio finished");
   endtask

   task automatic t_unserved();
      logic [7:0] bad [5];
      bad = '{8'h00, 8'h32, 8'h3E, 8'h45, 8'hFF};
      for (int k = 0; k < 5; k++)
         rd(bad[k], 16'h0000, 1'b0);
      $display("t_unserved finished");
   endtask

   // Cuts a hang short; the whole run needs well under this many cycles.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         num_errors++;
         test_done();
      end
   end

   initial
   begin
      repeat (4) @(posedge clk);
      #1;
      chk("reset valid", 16'h0000, {15'h0000, rd_valid});
      chk("reset data", RD_DATA_RST, rd_data);
      chk("reset hit", 16'h0000, {15'h0000, rd_hit});
      @(posedge clk);
      sys_rst <= 1'b0;
      t_flags();
      t_geom(16'h03E8, 16'h000F, 16'h003F, 32'h89AB_CDEF);
      t_geom(16'hFFFF, 16'h00FF, 16'h0011, 32'hFFFF_0001);
      t_mdma();
      t_dma_time();
      t_pio();
      t_unserved();
      test_done();
   end
endmodule
